// [adcte_engine.sv]
// Acquisition timing engine: triggers, sample and conversion gating
//
// Summary of operation
// - Conversion pulse output terminal is driven active low.
// - Internal conversion: programmable sample-to-first-conversion delay, default three ticks.
// - Sample and conversion pulses ignored until start trigger recognised.
// - After an accepted sample, further samples ignored until all conversions seen.
// - Conversion pulses before an accepted sample are discarded.
// - After the last conversion, extra conversion pulses ignored until next sample.
// - Mode where one external signal drives sample and conversion; tick converts once.
// - Conversion timebase is sample timebase or 20 MHz; divided; never output.
// - Hold-done pulse after each conversion begins; polarity selectable.
// - Acquisition starts on start trigger or software start command.
// - Finite ends on sample count or reference trigger; continuous on software stop.
// - Start trigger source selectable; starts on chosen rising or falling edge.
// - Start trigger output terminal is an active-high pulse.
// - Posttrigger count equals buffer size minus pretrigger count.
// - Reference trigger armed only after pretrigger samples captured.
// - Full buffer awaiting reference trigger overwrites the oldest sample.
// - After reference trigger, store posttrigger samples, then stop.
// - Reference trigger source selectable; stop on chosen edge.
// - Pause trigger at active level halts internal sample generator; level programmable.
// - Conversion divider starts on sample, counts down, pulses, reloads until done.
// - Sample counter loaded with count, decrements per sample, done at zero.
// - Internal sample: programmable start-to-first-sample delay, default two ticks.
`timescale 1ns/1ps
module adcte_engine
    import adcte_pkg::*;
#(
    parameter int NSRC = NUM_SRC,
    parameter int CW   = CNT_W
) (
    // Clock and reset
    input  wire logic            core_clk,
    input  wire logic            resetn,
    // Trigger and clock terminals, internal counter outputs
    input  wire logic [NSRC-1:0] srcIn,
    // Software commands (one-cycle pulses)
    input  wire logic            swStart,
    input  wire logic            swStop,
    // Configuration
    input  wire logic            useStartTrig,
    input  wire logic [SEL_W-1:0] startSel,
    input  wire logic            startFalling,
    input  wire logic            useRefTrig,
    input  wire logic [SEL_W-1:0] refSel,
    input  wire logic            refFalling,
    input  wire logic            usePause,
    input  wire logic [SEL_W-1:0] pauseSel,
    input  wire logic            pauseActiveLow,
    input  wire logic            continuous,
    input  wire logic            extSample,
    input  wire logic [SEL_W-1:0] sampleSel,
    input  wire logic            extConv,
    input  wire logic [SEL_W-1:0] convSel,
    input  wire logic            singleExt,
    input  wire logic            convTbFromSample,
    input  wire logic [CW-1:0]   sampleTbDiv,
    input  wire logic [CW-1:0]   sampleDiv,
    input  wire logic [CW-1:0]   convDiv,
    input  wire logic [CW-1:0]   sampleDelay,
    input  wire logic [CW-1:0]   convDelay,
    input  wire logic [CW-1:0]   numChannels,
    input  wire logic [CW-1:0]   sampleCount,
    input  wire logic [CW-1:0]   pretrigCount,
    input  wire logic            holdActiveLow,
    // Converter side
    output logic                 convertStart,
    output logic                 convertPulseN,
    output logic                 holdDonePulse,
    output logic                 samplePulse,
    output logic                 startTrigOut,
    output logic                 storeSample,
    output logic                 discardOldest,
    // Status
    output logic                 acqBusy,
    output logic                 acqDone,
    output logic                 refSeen
);
    logic [NSRC-1:0] srcLvl;
    logic [NSRC-1:0] srcRise;
    logic [NSRC-1:0] srcFall;

    adcte_edge_sync #(.W(NSRC)) uSync (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .rawIn     (srcIn),
        .syncLevel (srcLvl),
        .riseEdge  (srcRise),
        .fallEdge  (srcFall)
    );

    function automatic logic pickEdge(input logic [NSRC-1:0] r, input logic [NSRC-1:0] f,
                                      input logic [SEL_W-1:0] sel, input logic fall);
        pickEdge = fall ? f[sel] : r[sel];
    endfunction : pickEdge

    adcte_acq_e acqState;
    adcte_smp_e smpState;
    adcte_ref_e refState;
    logic [7:0]    tb20Cnt;
    logic [CW-1:0] stbCnt;
    logic [CW-1:0] sampDivCnt;
    logic [CW-1:0] convDivCnt;
    logic [CW-1:0] convLeft;
    logic [CW-1:0] sampLeft;
    logic [CW-1:0] stored;
    logic [CW-1:0] holdCnt;

    // Trigger edges and timebases
    wire startEdge = pickEdge(srcRise, srcFall, startSel, startFalling);
    wire refEdge   = pickEdge(srcRise, srcFall, refSel, refFalling);
    wire pauseOn   = usePause && (srcLvl[pauseSel] ^ pauseActiveLow);
    wire tb20Tick  = (tb20Cnt == 8'(TB20_DIV - 1));
    wire stbTick   = tb20Tick && (stbCnt == '0);
    wire ctbTick   = convTbFromSample ? stbTick : tb20Tick;
    wire running   = (acqState == ACQ_RUN);
    wire intSamp   = running && !pauseOn && stbTick && (sampDivCnt == '0);
    wire extSampEv = singleExt ? srcRise[sampleSel] : srcRise[sampleSel];
    wire rawSample = (extSample || singleExt) ? extSampEv : intSamp;
    wire acceptSmp = running && rawSample && (smpState == SMP_WAIT);
    wire intConv   = (smpState == SMP_CONVERT) && ctbTick && (convDivCnt == '0);
    wire rawConv   = singleExt ? acceptSmp : (extConv ? srcRise[convSel] : intConv);
    wire convOk    = singleExt ? acceptSmp : (rawConv && smpState == SMP_CONVERT);
    wire convCount = singleExt ? 1'b1 : (numChannels == '0 ? 1'b1 : 1'b0);
    wire lastConv  = convOk && (singleExt || convLeft <= 1 || convCount);
    wire [CW-1:0] postCount = sampleCount - pretrigCount;
    wire goStart   = (acqState == ACQ_WAIT_START) && (useStartTrig ? startEdge : 1'b1);

    // Timebase dividers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tb20Cnt <= '0;
            stbCnt  <= '0;
        end else begin
            tb20Cnt <= tb20Tick ? '0 : tb20Cnt + 8'h01;
            if (tb20Tick)
                stbCnt <= (stbCnt == '0) ? sampleTbDiv : stbCnt - 1'b1;
        end
    end

    // Acquisition state
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            acqState     <= ACQ_IDLE;
            sampDivCnt   <= '0;
            startTrigOut <= 1'b0;
        end else begin
            startTrigOut <= 1'b0;
            case (acqState)
                ACQ_IDLE, ACQ_DONE: begin
                    if (swStart)
                        acqState <= ACQ_WAIT_START;
                end
                ACQ_WAIT_START: begin
                    if (swStop)
                        acqState <= ACQ_IDLE;
                    else if (goStart) begin
                        acqState     <= ACQ_START_DELAY;
                        startTrigOut <= 1'b1;
                        sampDivCnt   <= sampleDelay;
                    end
                end
                ACQ_START_DELAY: begin
                    if (swStop)
                        acqState <= ACQ_IDLE;
                    else if (extSample || singleExt)
                        acqState <= ACQ_RUN;
                    else if (stbTick) begin
                        if (sampDivCnt <= 1) begin
                            acqState   <= ACQ_RUN;
                            sampDivCnt <= '0;
                        end else
                            sampDivCnt <= sampDivCnt - 1'b1;
                    end
                end
                default: begin
                    if (swStop)
                        acqState <= ACQ_DONE;
                    else if (acceptSmp && !continuous &&
                             ((useRefTrig && refState == REF_POST && sampLeft == 1) ||
                              (!useRefTrig && sampLeft == 1)))
                        acqState <= ACQ_DONE;
                    if (intSamp)
                        sampDivCnt <= sampleDiv;
                    else if (stbTick && !pauseOn && sampDivCnt != '0)
                        sampDivCnt <= sampDivCnt - 1'b1;
                end
            endcase
        end
    end

    // Sample counter and reference trigger
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            refState <= REF_OFF;
            sampLeft <= '0;
            stored   <= '0;
            refSeen  <= 1'b0;
        end else if (goStart) begin
            refState <= useRefTrig ? REF_PRE : REF_OFF;
            sampLeft <= useRefTrig ? pretrigCount : sampleCount;
            stored   <= '0;
            refSeen  <= 1'b0;
        end else if (running) begin
            if (acceptSmp && stored != sampleCount)
                stored <= stored + 1'b1;
            case (refState)
                REF_PRE: begin
                    if (acceptSmp && sampLeft <= 1)
                        refState <= REF_ARMED;
                    else if (acceptSmp)
                        sampLeft <= sampLeft - 1'b1;
                end
                REF_ARMED: begin
                    if (refEdge) begin
                        refState <= REF_POST;
                        refSeen  <= 1'b1;
                        sampLeft <= postCount;
                    end
                end
                REF_POST: begin
                    if (acceptSmp)
                        sampLeft <= sampLeft - 1'b1;
                end
                default: begin
                    if (acceptSmp && sampLeft != '0)
                        sampLeft <= sampLeft - 1'b1;
                end
            endcase
        end
    end

    // Per-sample conversions; the last sample still completes after a finite stop
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            smpState   <= SMP_WAIT;
            convDivCnt <= '0;
            convLeft   <= '0;
        end else if (!running && acqState != ACQ_DONE) begin
            smpState   <= SMP_WAIT;
            convDivCnt <= '0;
        end else begin
            case (smpState)
                SMP_WAIT: begin
                    if (acceptSmp && !singleExt) begin
                        smpState   <= SMP_CONVERT;
                        convLeft   <= numChannels;
                        convDivCnt <= convDelay;
                    end
                end
                default: begin
                    if (lastConv) begin
                        smpState   <= SMP_WAIT;
                        convDivCnt <= convDiv;
                    end else if (convOk) begin
                        convLeft   <= convLeft - 1'b1;
                        convDivCnt <= convDiv;
                    end else if (ctbTick && !extConv && convDivCnt != '0)
                        convDivCnt <= convDivCnt - 1'b1;
                end
            endcase
        end
    end

    // Outputs, all registered
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            convertStart  <= 1'b0;
            convertPulseN <= 1'b1;
            holdDonePulse <= 1'b0;
            holdCnt       <= '0;
            samplePulse   <= 1'b0;
            storeSample   <= 1'b0;
            discardOldest <= 1'b0;
            acqBusy       <= 1'b0;
            acqDone       <= 1'b0;
        end else begin
            convertStart  <= convOk;
            convertPulseN <= !convOk;
            samplePulse   <= acceptSmp;
            storeSample   <= acceptSmp;
            // Oldest entry dropped only while still hunting for the trigger
            discardOldest <= acceptSmp && useRefTrig && refState != REF_POST &&
                             stored == sampleCount;
            // Hold-done follows the conversion start by one cycle
            if (convertStart)
                holdCnt <= CW'(HOLD_PULSE_CYC);
            else if (holdCnt != '0)
                holdCnt <= holdCnt - 1'b1;
            holdDonePulse <= ((holdCnt != '0) || convertStart) ^ holdActiveLow;
            acqBusy       <= (acqState != ACQ_IDLE) && (acqState != ACQ_DONE);
            acqDone       <= (acqState == ACQ_DONE);
        end
    end
endmodule : adcte_engine

// [adcte_pkg.sv]
// Package of constants and types for the acquisition timing engine
package adcte_pkg;
    localparam int TIMEBASE_MHZ     = 20;
    localparam int CORE_CLK_MHZ     = 125;
    // 20 MHz tick from 125 MHz core: period rounded down to whole cycles
    localparam int TB20_DIV         = CORE_CLK_MHZ / TIMEBASE_MHZ;
    localparam int CNT_W            = 16;
    localparam int SEL_W            = 3;
    localparam int NUM_SRC          = 8;
    localparam logic [CNT_W-1:0] CONV_DELAY_RST  = 16'h0003;
    localparam logic [CNT_W-1:0] SAMP_DELAY_RST  = 16'h0002;
    localparam int HOLD_PULSE_CYC   = 2;

    typedef enum logic [2:0] {
        ACQ_IDLE,
        ACQ_WAIT_START,
        ACQ_START_DELAY,
        ACQ_RUN,
        ACQ_DONE
    } adcte_acq_e;

    typedef enum logic [1:0] {
        SMP_WAIT,
        SMP_DELAY,
        SMP_CONVERT
    } adcte_smp_e;

    typedef enum logic [1:0] {
        REF_OFF,
        REF_PRE,
        REF_ARMED,
        REF_POST
    } adcte_ref_e;
endpackage : adcte_pkg

// [adcte_edge_sync.sv]
// Input synchroniser and edge detector for trigger and clock terminals
`timescale 1ns/1ps
module adcte_edge_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         resetn,
    // Raw inputs
    input  wire logic [W-1:0] rawIn,
    // Synchronised level and edges
    output logic [W-1:0]      syncLevel,
    output logic [W-1:0]      riseEdge,
    output logic [W-1:0]      fallEdge
);
    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] last;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            meta   <= '0;
            stable <= '0;
            last   <= '0;
        end else begin
            meta   <= rawIn;
            stable <= meta;
            last   <= stable;
        end
    end

    assign syncLevel = stable;
    assign riseEdge  = stable & ~last;
    assign fallEdge  = ~stable & last;
endmodule : adcte_edge_sync

// [adcte_engine_asserts.sv]
// Assertion checker bound to the acquisition timing engine
`timescale 1ns/1ps
module adcte_engine_asserts
    import adcte_pkg::*;
#(
    parameter int NSRC = NUM_SRC,
    parameter int CW   = CNT_W
) (
    // Clock and reset
    input wire logic          core_clk,
    input wire logic          resetn,
    // Configuration
    input wire logic          extConv,
    input wire logic          extSample,
    input wire logic          singleExt,
    input wire logic          holdActiveLow,
    input wire logic [CW-1:0] numChannels,
    // Engine outputs
    input wire logic          convertStart,
    input wire logic          convertPulseN,
    input wire logic          holdDonePulse,
    input wire logic          samplePulse,
    input wire logic          startTrigOut,
    input wire logic          storeSample,
    input wire logic          discardOldest,
    input wire logic          acqDone,
    input wire logic          refSeen
);
    // Conversions since the last accepted sample
    logic [CW-1:0] convSeen;
    logic          inSample;
    wire  [CW-1:0] chanNeed = (numChannels == '0) ? CW'(1) : numChannels;
    wire           holdOn   = holdDonePulse ^ holdActiveLow;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            convSeen <= '0;
            inSample <= 1'b0;
        end else begin
            convSeen <= samplePulse ? '0 : convSeen + CW'(convertStart);
            inSample <= (inSample || samplePulse) && !startTrigOut;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_conv_low; convertPulseN == !convertStart; endproperty
    a_conv_low: assert property (p_conv_low) else $error("conversion pin wrong");
    property p_hold; convertStart |=> holdOn [*3] ##1 !holdOn; endproperty
    a_hold: assert property (p_hold) else $error("hold pulse shape wrong");
    property p_conv_delay;
        samplePulse && !extConv && !singleExt |-> !convertStart [*8];
    endproperty
    a_conv_delay: assert property (p_conv_delay) else $error("conversion too early");
    property p_start_delay;
        startTrigOut && !extSample && !singleExt |=> !samplePulse [*8];
    endproperty
    a_start_delay: assert property (p_start_delay) else $error("sample too early");
    property p_store; samplePulse == storeSample; endproperty
    a_store: assert property (p_store) else $error("store not with sample");
    property p_discard; discardOldest |-> storeSample && !refSeen; endproperty
    a_discard: assert property (p_discard) else $error("discard out of place");
    property p_full_count;
        samplePulse && inSample && !singleExt |-> convSeen == chanNeed;
    endproperty
    a_full_count: assert property (p_full_count) else $error("sample too soon");
    property p_no_extra; convertStart && !singleExt |-> convSeen < chanNeed; endproperty
    a_no_extra: assert property (p_no_extra) else $error("extra conversion taken");
    property p_done_quiet; acqDone && $past(acqDone) |-> !samplePulse; endproperty
    a_done_quiet: assert property (p_done_quiet) else $error("sample after done");
endmodule : adcte_engine_asserts
bind adcte_engine adcte_engine_asserts #(.NSRC(NSRC), .CW(CW)) i_adcte_engine_asserts (
    .core_clk, .resetn, .extConv, .extSample, .singleExt, .holdActiveLow, .numChannels,
    .convertStart, .convertPulseN, .holdDonePulse, .samplePulse, .startTrigOut, .storeSample,
    .discardOldest, .acqDone, .refSeen
);

// [adcte_far_model.sv]
// Far-side model: trigger and clock terminals plus an external channel mux
`timescale 1ns/1ps
module adcte_far_model (
    // Clock
    input  wire logic core_clk,
    // Hold-done feedback
    input  wire logic holdDonePulse,
    input  wire logic holdActiveLow,
    // Terminals towards the engine
    output logic [7:0] srcIn,
    // Mux position
    output int         muxCount
);
    initial begin
        srcIn = 8'h00;
        muxCount = 0;
    end
    // Leading edge only, so a polarity change between runs never steps it
    always @(posedge core_clk) begin
        if (holdActiveLow ? $fell(holdDonePulse) : $rose(holdDonePulse))
            muxCount <= muxCount + 1;
    end
    // Level held ten cycles so the synchroniser cannot miss it
    task automatic setPin(input int idx, input logic val);
        @(posedge core_clk);
        #1;
        srcIn[idx] = val;
        repeat (10) @(posedge core_clk);
    endtask : setPin
    task automatic pulse(input int idx);
        setPin(idx, 1'b1);
        setPin(idx, 1'b0);
    endtask : pulse
endmodule : adcte_far_model

// [adcte_engine_tb_top.sv]
// Self-checking testbench for the acquisition timing engine
`timescale 1ns/1ps
module adcte_engine_tb_top;
    import adcte_pkg::*;
    typedef struct {int smp; int conv; int disc; int strt;} adcte_note_s;
    logic             core_clk = 1'b0;
    logic             resetn;
    logic             swStart, swStop, useStartTrig, startFalling, useRefTrig, refFalling;
    logic             usePause, pauseActiveLow, continuous, extSample, extConv, singleExt;
    logic             convTbFromSample, holdActiveLow;
    logic [SEL_W-1:0] startSel, refSel, pauseSel, sampleSel, convSel;
    logic [CNT_W-1:0] sampleTbDiv, sampleDiv, convDiv, sampleDelay, convDelay;
    logic [CNT_W-1:0] numChannels, sampleCount, pretrigCount;
    logic             convertStart, convertPulseN, holdDonePulse, samplePulse, startTrigOut;
    logic             storeSample, discardOldest, acqBusy, acqDone, refSeen;
    logic [7:0]       srcIn;
    int               muxCount, muxBase, nSmp, nConv, nDisc, nStrt, cycles, errors, n_compared;
    adcte_note_s      notes[$];
    always #4 core_clk = ~core_clk;
    adcte_engine i_adcte_engine (
        .core_clk, .resetn, .srcIn, .swStart, .swStop, .useStartTrig, .startSel, .startFalling,
        .useRefTrig, .refSel, .refFalling, .usePause, .pauseSel, .pauseActiveLow, .continuous,
        .extSample, .sampleSel, .extConv, .convSel, .singleExt, .convTbFromSample, .sampleTbDiv,
        .sampleDiv, .convDiv, .sampleDelay, .convDelay, .numChannels, .sampleCount, .pretrigCount,
        .holdActiveLow, .convertStart, .convertPulseN, .holdDonePulse, .samplePulse, .startTrigOut,
        .storeSample, .discardOldest, .acqBusy, .acqDone, .refSeen
    );
    adcte_far_model i_adcte_far_model (
        .core_clk, .holdDonePulse, .holdActiveLow, .srcIn, .muxCount
    );
    task automatic chk(input string name, input int exp, input int got);
        n_compared++;
        if (exp !== got) begin
            errors++;
            $display("unexpected %s: expected %0d, seen %0d", name, exp, got);
        end
    endtask : chk
    task automatic chkBit(input string name, input logic exp, input logic got);
        n_compared++;
        if (exp !== got) begin
            errors++;
            $display("unexpected %s: expected %b, seen %b", name, exp, got);
        end
    endtask : chkBit
    task automatic report_and_stop();
        if (errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic setDefaults();
        {swStart, swStop, useStartTrig, startFalling, useRefTrig, refFalling} = '0;
        {usePause, pauseActiveLow, continuous, extSample, extConv, singleExt} = '0;
        {convTbFromSample, holdActiveLow} = '0;
        {startSel, refSel, pauseSel, sampleSel, convSel} = {3'h2, 3'h3, 3'h4, 3'h0, 3'h1};
        {sampleTbDiv, convDiv} = {16'h0, 16'h2};
        {sampleDelay, convDelay} = {SAMP_DELAY_RST, CONV_DELAY_RST};
        {sampleDiv, numChannels, sampleCount, pretrigCount} = {16'h28, 16'h1, 16'h1, 16'h0};
    endtask : setDefaults
    task automatic go();
        tick(1);
        swStart = 1'b1;
        tick(1);
        swStart = 1'b0;
    endtask : go
    task automatic drain();
        for (int k = 0; k < 5000 && notes.size() != 0; k++) tick(1);
        chk("pendingNotes", 0, notes.size());
    endtask : drain
    // s: sample pin, c: conversion pin, r: one reference edge
    task automatic seq(input string s);
        for (int k = 0; k < s.len(); k++) begin
            if (s[k] == "r") begin
                i_adcte_far_model.setPin(3, !refFalling);
                i_adcte_far_model.setPin(3, refFalling);
            end else begin
                i_adcte_far_model.pulse(s[k] == "s" ? int'(sampleSel) : 1);
            end
        end
    endtask : seq
    always @(posedge core_clk) begin
        cycles++;
        if (samplePulse === 1'b1) nSmp++;
        if (convertStart === 1'b1) nConv++;
        if (discardOldest === 1'b1) nDisc++;
        if (startTrigOut === 1'b1) nStrt++;
        if (cycles == 20000) begin
            chk("timeout", 0, cycles);
            report_and_stop();
        end
    end
    // Late compare: the last conversions of a run may trail the busy flag
    initial forever begin
        adcte_note_s n;
        @(negedge acqBusy);
        if (resetn === 1'b1 && notes.size() != 0) begin
            tick(300);
            n = notes.pop_front();
            chk("samples", n.smp, nSmp);
            chk("conversions", n.conv, nConv);
            chk("discards", n.disc, nDisc);
            chk("startPulses", n.strt, nStrt);
            chk("muxSteps", n.conv, muxCount - muxBase);
            chkBit("acqDone", 1'b1, acqDone);
            chkBit("refSeen", useRefTrig, refSeen);
            {nSmp, nConv, nDisc, nStrt} = '0;
            muxBase = muxCount;
        end
    end
    initial begin
        resetn = 1'b0;
        setDefaults();
        void'($urandom(32'h6a50));
        tick(12);
        chkBit("convertPulseN", 1'b1, convertPulseN);
        resetn = 1'b1;
        for (int i = 0; i < 2; i++) begin
            tick(1);
            setDefaults();
            sampleCount = 16'h3;
            numChannels = CNT_W'(1 + $urandom_range(3));
            convDiv = CNT_W'(1 + $urandom_range(1));
            sampleTbDiv = CNT_W'(i);
            {convTbFromSample, holdActiveLow, usePause, pauseActiveLow} = {4{i[0]}};
            notes.push_back('{3, 3 * int'(numChannels), 0, 1});
            go();
            if (i == 1) begin
                tick(600);
                chk("pausedSamples", 0, nSmp);
                i_adcte_far_model.setPin(4, 1'b1);
            end
            drain();
        end
        for (int fe = 0; fe < 2; fe++) begin
            tick(1);
            setDefaults();
            {extSample, extConv, useStartTrig, startFalling} = {3'b111, fe[0]};
            {numChannels, sampleCount} = {16'h2, 16'h2};
            startSel = SEL_W'(2 + 4 * $urandom_range(1));
            i_adcte_far_model.setPin(int'(startSel), fe[0]);
            notes.push_back('{2, 4, 0, 1});
            seq("sc");
            go();
            seq("sc");
            i_adcte_far_model.setPin(int'(startSel), !fe[0]);
            seq("cssccc");
            seq("scc");
            drain();
        end
        tick(1);
        setDefaults();
        {extSample, singleExt, continuous, sampleSel} = {3'b111, 3'h5};
        notes.push_back('{3, 3, 0, 1});
        go();
        seq("sss");
        tick(1);
        swStop = 1'b1;
        tick(1);
        swStop = 1'b0;
        drain();
        tick(1);
        setDefaults();
        {extSample, extConv, useRefTrig} = 3'b111;
        refFalling = 1'($urandom_range(1));
        {sampleCount, pretrigCount} = {16'h6, 16'h2};
        i_adcte_far_model.setPin(3, refFalling);
        notes.push_back('{12, 12, 2, 1});
        go();
        seq("scrscscscscscscscrscscscscscscsc");
        drain();
        report_and_stop();
    end
endmodule : adcte_engine_tb_top
